/* File: include/kbcmd_regs.vh */
// constants of the keyboard controller command decoder
`ifndef KBCMD_REGS_VH
`define KBCMD_REGS_VH

// --------------------------------------------------------------
// wishbone register offsets (byte addresses)
// --------------------------------------------------------------
`define KBCMD_ADDR_DATA      4'h0
`define KBCMD_ADDR_CMD       4'h4
`define KBCMD_ADDR_STATUS    4'h8
`define KBCMD_ADDR_MODE      4'hc

// --------------------------------------------------------------
// status and mode fields
// --------------------------------------------------------------
`define KBCMD_ST_OUT_FULL    0
`define KBCMD_ST_CMD_DATA    3
`define KBCMD_ST_KBD_EN      4
`define KBCMD_ST_SRC_PTR     5
`define KBCMD_MODE_KBIRQ_EN  0
`define KBCMD_MODE_PIRQ_EN   1
`define KBCMD_MODE_KBD_DIS   4
`define KBCMD_MODE_RESET     8'h00
`define KBCMD_OPORT_RESET    8'hcf

// --------------------------------------------------------------
// command codes and results
// --------------------------------------------------------------
`define KBCMD_C_RD_MODE      8'h20
`define KBCMD_C_WR_MODE      8'h60
`define KBCMD_C_MOUSE_TEST   8'ha9
`define KBCMD_C_SELF_TEST    8'haa
`define KBCMD_C_KBD_TEST     8'hab
`define KBCMD_C_DUMP         8'hac
`define KBCMD_C_KBD_DIS      8'had
`define KBCMD_C_KBD_EN       8'hae
`define KBCMD_C_RD_IN        8'hc0
`define KBCMD_C_POLL_LO      8'hc1
`define KBCMD_C_POLL_HI      8'hc2
`define KBCMD_C_RD_OUT       8'hd0
`define KBCMD_C_WR_OUT       8'hd1
`define KBCMD_C_WR_KBUF      8'hd2
`define KBCMD_C_WR_PBUF      8'hd3
`define KBCMD_C_WR_PTR       8'hd4
`define KBCMD_C_RD_TEST      8'he0
`define KBCMD_SELF_OK        8'h55
`define KBCMD_DUMP_LEN       5'd18

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define KBCMD_CLK_KHZ        25000
`define KBCMD_PULSE_NS       6000
`define KBCMD_PULSE_CYC      ((`KBCMD_PULSE_NS * `KBCMD_CLK_KHZ) / 1000000)

`endif

/* File: logic/kbcmd_line_test.v */
// line test result encoder for one clock and data pair
`timescale 1ns/1ps
`default_nettype none

module kbcmd_line_test
(
    // sampled line levels and the levels this end drives
    input  wire       clk_level_i,
    input  wire       dat_level_i,
    input  wire       clk_drive_i,
    input  wire       dat_drive_i,
    // result code
    output reg  [7:0] code_o
);

    // a line that disagrees with its own drive is stuck
    always @*
    begin
        if (!clk_level_i && clk_drive_i)
            code_o = 8'h01;
        else if (clk_level_i && !clk_drive_i)
            code_o = 8'h02;
        else if (!dat_level_i && dat_drive_i)
            code_o = 8'h03;
        else if (dat_level_i && !dat_drive_i)
            code_o = 8'h04;
        else
            code_o = 8'h00;
    end

endmodule
`default_nettype wire

/* File: logic/kbcmd_pulse.v */
// one low pulse timer for an output port bit
`timescale 1ns/1ps
`default_nettype none
`include "kbcmd_regs.vh"

module kbcmd_pulse
(
    // clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // start request
    input  wire start_i,
    // pulse active
    output reg  low_o
);

    localparam integer CYC_INT = `KBCMD_PULSE_CYC;
    localparam [7:0]   CYCLES  = CYC_INT[7:0];

    reg [7:0] cnt_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 8'h00;
            low_o   <= 1'b0;
        end
        else if (start_i)
        begin
            cnt_reg <= CYCLES - 8'h01;
            low_o   <= 1'b1;
        end
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
        else
            low_o <= 1'b0;
    end

endmodule
`default_nettype wire

/* File: logic/kbcmd_top.v */
// keyboard controller command decoder with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "kbcmd_regs.vh"

module kbcmd_top
(
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // mode strap: 1 selects extended mode
    input  wire        ext_mode_i,
    // input port and test pins
    input  wire [7:0]  input_port_i,
    input  wire        kbd_clock_line_i,
    input  wire        kbd_data_line_i,
    input  wire        ptr_clock_line_i,
    input  wire        ptr_data_line_i,
    // keyboard clock open drain, oe low while driving
    output reg         kbd_clock_line_o,
    output reg         kbd_clock_line_oe_n_o,
    // output port and interrupts
    output reg  [7:0]  output_port_o,
    output reg         kbd_irq_o,
    output reg         pointer_irq_o,
    // bytes forwarded to the serial links
    output reg  [7:0]  tx_data_o,
    output reg         kbd_tx_o,
    output reg         ptr_tx_o
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    localparam [2:0] EXP_NONE = 3'd0;
    localparam [2:0] EXP_MODE = 3'd1;
    localparam [2:0] EXP_OUT  = 3'd2;
    localparam [2:0] EXP_KBUF = 3'd3;
    localparam [2:0] EXP_PBUF = 3'd4;
    localparam [2:0] EXP_PTR  = 3'd5;

    localparam [1:0] POLL_OFF = 2'd0;
    localparam [1:0] POLL_LO  = 2'd1;
    localparam [1:0] POLL_HI  = 2'd2;

    reg [7:0] ram [0:15];
    reg [7:0] out_buf_reg;
    reg       out_full_flag_reg;
    reg       src_ptr_reg;
    reg       cmd_data_reg;
    reg [7:0] mode_reg;
    reg [7:0] oport_reg;
    reg [2:0] expect_reg;
    reg [1:0] poll_reg;
    reg [4:0] dump_cnt_reg;
    reg       ext_reg;
    reg       strap_done_reg;
    reg [1:0] kc_s, kd_s, pc_s, pd_s;
    reg [1:0] ext_s;
    reg [7:0] ip_s1, ip_s2;
    reg       start2_reg;
    reg       start3_reg;

    wire       kc = kc_s[1];
    wire       kd = kd_s[1];
    wire       pc = pc_s[1];
    wire       pd = pd_s[1];
    wire       low2;
    wire       low3;
    wire [7:0] kbd_code;
    wire [7:0] ptr_code;
    integer    i;

    // ----------------------------------------------------------
    // pin synchronisers and helpers
    // ----------------------------------------------------------
    always @(posedge clk_i)
    begin
        kc_s  <= {kc_s[0], kbd_clock_line_i};
        kd_s  <= {kd_s[0], kbd_data_line_i};
        pc_s  <= {pc_s[0], ptr_clock_line_i};
        pd_s  <= {pd_s[0], ptr_data_line_i};
        ext_s <= {ext_s[0], ext_mode_i};
        ip_s1 <= input_port_i;
        ip_s2 <= ip_s1;
    end

    kbcmd_line_test u_kbd_test
    (
        .clk_level_i (kc),
        .dat_level_i (kd),
        .clk_drive_i (!mode_reg[`KBCMD_MODE_KBD_DIS]),
        .dat_drive_i (1'b1),
        .code_o      (kbd_code)
    );

    kbcmd_line_test u_ptr_test
    (
        .clk_level_i (pc),
        .dat_level_i (pd),
        .clk_drive_i (1'b1),
        .dat_drive_i (1'b1),
        .code_o      (ptr_code)
    );

    kbcmd_pulse u_pulse2
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (start2_reg),
        .low_o   (low2)
    );

    kbcmd_pulse u_pulse3
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (start3_reg),
        .low_o   (low3)
    );

    // output port view, mode dependent
    function [7:0] oport_view;
        input [7:0] p;
        input       ext;
        input       full;
        input       kbd_irq;
        input       pirq;
        input       kco;
        input       kdo;
        begin
            if (ext)
                oport_view = {~kdo, ~kco, pirq, kbd_irq, pc, pd, p[1:0]};
            else
                oport_view = {kdo, kco, p[5], full, p[3:0]};
        end
    endfunction

    // ----------------------------------------------------------
    // decoder
    // ----------------------------------------------------------
    wire       acc    = cyc_i && stb_i && !ack_o;
    wire       wr     = acc && we_i && sel_i[0];
    wire       wr_cmd = wr && (adr_i == `KBCMD_ADDR_CMD);
    wire       wr_dat = wr && (adr_i == `KBCMD_ADDR_DATA);
    wire       rd_dat = acc && !we_i && (adr_i == `KBCMD_ADDR_DATA);
    wire [7:0] cmd    = dat_i[7:0];
    wire [7:0] oview  = oport_view(oport_reg, ext_reg, out_full_flag_reg,
                                   kbd_irq_o, pointer_irq_o, 1'b0, 1'b0);
    wire [7:0] keep   = ext_reg ? 8'hcc : 8'hc0;
    wire [4:0] dump_idx = `KBCMD_DUMP_LEN - dump_cnt_reg;

    // combined load into the output buffer
    reg        load;
    reg        load_ptr;
    reg [7:0]  load_val;

    always @*
    begin
        load     = 1'b0;
        load_ptr = 1'b0;
        load_val = 8'h00;
        if (dump_cnt_reg != 5'd0 && !out_full_flag_reg)
        begin
            load = 1'b1;
            if (dump_cnt_reg > 5'd2)
                load_val = ram[dump_idx[3:0]];
            else if (dump_cnt_reg == 5'd2)
                load_val = ip_s2;
            else
                load_val = oview;
        end
        if (wr_cmd)
        begin
            load = 1'b1;
            if (cmd == `KBCMD_C_RD_MODE)
                load_val = mode_reg;
            else if (cmd == `KBCMD_C_SELF_TEST)
                load_val = `KBCMD_SELF_OK;
            else if (cmd == `KBCMD_C_KBD_TEST)
                load_val = kbd_code;
            else if (cmd == `KBCMD_C_MOUSE_TEST && ext_reg)
                load_val = ptr_code;
            else if (cmd == `KBCMD_C_RD_IN)
                load_val = ip_s2;
            else if (cmd == `KBCMD_C_RD_OUT)
                load_val = oview;
            else if (cmd == `KBCMD_C_RD_TEST)
                load_val = {6'h00, ext_reg ? pc : kd, kc};
            else
                // keep a pending dump byte, the command itself loads nothing
                load = (dump_cnt_reg != 5'd0 && !out_full_flag_reg);
        end
        if (wr_dat && (expect_reg == EXP_KBUF || expect_reg == EXP_PBUF))
        begin
            load     = 1'b1;
            load_ptr = (expect_reg == EXP_PBUF);
            load_val = dat_i[7:0];
        end
    end

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_buf_reg       <= 8'h00;
            out_full_flag_reg <= 1'b0;
            src_ptr_reg       <= 1'b0;
            cmd_data_reg      <= 1'b0;
            mode_reg          <= `KBCMD_MODE_RESET;
            oport_reg         <= `KBCMD_OPORT_RESET;
            expect_reg        <= EXP_NONE;
            poll_reg          <= POLL_OFF;
            dump_cnt_reg      <= 5'd0;
            ext_reg           <= 1'b0;
            strap_done_reg    <= 1'b0;
            kbd_irq_o         <= 1'b0;
            pointer_irq_o     <= 1'b0;
            tx_data_o         <= 8'h00;
            kbd_tx_o          <= 1'b0;
            ptr_tx_o          <= 1'b0;
            start2_reg        <= 1'b0;
            start3_reg        <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
                ram[i] <= 8'h00;
        end
        else
        begin
            kbd_tx_o   <= 1'b0;
            ptr_tx_o   <= 1'b0;
            start2_reg <= 1'b0;
            start3_reg <= 1'b0;
            if (!strap_done_reg)
            begin
                ext_reg        <= ext_s[1];
                strap_done_reg <= 1'b1;
            end
            // read clears, a load in the same cycle wins
            if (rd_dat)
            begin
                out_full_flag_reg <= 1'b0;
                kbd_irq_o         <= 1'b0;
                pointer_irq_o     <= 1'b0;
            end
            if (load)
            begin
                out_buf_reg       <= load_val;
                out_full_flag_reg <= 1'b1;
                src_ptr_reg       <= load_ptr;
                if (load_ptr)
                    pointer_irq_o <= mode_reg[`KBCMD_MODE_PIRQ_EN];
                else
                    kbd_irq_o <= mode_reg[`KBCMD_MODE_KBIRQ_EN];
            end
            if (dump_cnt_reg != 5'd0 && !out_full_flag_reg)
                dump_cnt_reg <= dump_cnt_reg - 5'd1;
            if (wr_cmd)
            begin
                cmd_data_reg <= 1'b1;
                expect_reg   <= EXP_NONE;
                poll_reg     <= POLL_OFF;
                if (cmd == `KBCMD_C_WR_MODE)
                    expect_reg <= EXP_MODE;
                else if (cmd == `KBCMD_C_DUMP && !ext_reg)
                    dump_cnt_reg <= `KBCMD_DUMP_LEN;
                else if (cmd == `KBCMD_C_KBD_DIS)
                    mode_reg[`KBCMD_MODE_KBD_DIS] <= 1'b1;
                else if (cmd == `KBCMD_C_KBD_EN)
                    mode_reg[`KBCMD_MODE_KBD_DIS] <= 1'b0;
                else if (cmd == `KBCMD_C_POLL_LO && ext_reg)
                    poll_reg <= POLL_LO;
                else if (cmd == `KBCMD_C_POLL_HI && ext_reg)
                    poll_reg <= POLL_HI;
                else if (cmd == `KBCMD_C_WR_OUT)
                    expect_reg <= EXP_OUT;
                else if (cmd == `KBCMD_C_WR_KBUF && ext_reg)
                    expect_reg <= EXP_KBUF;
                else if (cmd == `KBCMD_C_WR_PBUF && ext_reg)
                    expect_reg <= EXP_PBUF;
                else if (cmd == `KBCMD_C_WR_PTR && ext_reg)
                    expect_reg <= EXP_PTR;
                else if (cmd[7:4] == 4'hf && !ext_reg)
                begin
                    start2_reg <= !cmd[2];
                    start3_reg <= !cmd[3];
                end
            end
            if (wr_dat)
            begin
                cmd_data_reg <= 1'b0;
                expect_reg   <= EXP_NONE;
                if (expect_reg == EXP_MODE)
                    mode_reg <= dat_i[7:0];
                else if (expect_reg == EXP_OUT)
                    oport_reg <= (oport_reg & keep) | (dat_i[7:0] & ~keep);
                else if (expect_reg == EXP_PTR)
                begin
                    tx_data_o <= dat_i[7:0];
                    ptr_tx_o  <= 1'b1;
                end
                else if (expect_reg == EXP_NONE)
                begin
                    tx_data_o <= dat_i[7:0];
                    kbd_tx_o  <= 1'b1;
                    mode_reg[`KBCMD_MODE_KBD_DIS] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------
    // pins and bus answer
    // ----------------------------------------------------------
    reg [7:0] status;

    always @*
    begin
        status = {2'b00, src_ptr_reg, !mode_reg[`KBCMD_MODE_KBD_DIS],
                  cmd_data_reg, 2'b00, out_full_flag_reg};
        if (poll_reg == POLL_LO)
            status[7:4] = ip_s2[3:0];
        else if (poll_reg == POLL_HI)
            status[7:4] = ip_s2[7:4];
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o                 <= 1'b0;
            dat_o                 <= 32'h00000000;
            kbd_clock_line_o      <= 1'b0;
            kbd_clock_line_oe_n_o <= 1'b1;
            output_port_o         <= `KBCMD_OPORT_RESET;
        end
        else
        begin
            ack_o <= acc;
            if (acc && !we_i)
            begin
                if (adr_i == `KBCMD_ADDR_DATA)
                    dat_o <= {24'h000000, out_buf_reg};
                else if (adr_i == `KBCMD_ADDR_STATUS)
                    dat_o <= {24'h000000, status};
                else if (adr_i == `KBCMD_ADDR_MODE)
                    dat_o <= {24'h000000, mode_reg};
                else
                    dat_o <= 32'h00000000;
            end
            kbd_clock_line_o      <= 1'b0;
            kbd_clock_line_oe_n_o <= !mode_reg[`KBCMD_MODE_KBD_DIS];
            output_port_o <= {oport_reg[7:4],
                              oport_reg[3] & !low3,
                              oport_reg[2] & !low2,
                              oport_reg[1:0]};
        end
    end

endmodule
`default_nettype wire

/* File: tb/kbcmd_assertions.sv */
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "kbcmd_regs.vh"

module kbcmd_top_checker
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins
    input wire logic        ext_mode_i,
    input wire logic        kbd_clock_line_oe_n_o,
    input wire logic [7:0]  output_port_o,
    input wire logic        kbd_irq_o,
    input wire logic        pointer_irq_o,
    input wire logic        kbd_tx_o,
    input wire logic        ptr_tx_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [8:0] lo_cnt;
    wire        wr_cmd;

    assign wr_cmd = cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                    && adr_i == `KBCMD_ADDR_CMD;

    // saturates so a stuck-low bit cannot wrap back into range
    always @(posedge clk_i)
    begin
        if (rst_i || output_port_o[2])
            lo_cnt <= 9'h000;
        else if (lo_cnt != 9'h1ff)
            lo_cnt <= lo_cnt + 9'h001;
    end

    AST_ACK_TIME: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_RD_HIGH: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RST_STATE: assert property (disable iff (1'b0) rst_i |=> !ack_o
        && kbd_clock_line_oe_n_o && output_port_o == `KBCMD_OPORT_RESET
        && !kbd_irq_o && !pointer_irq_o)
        else $error("wrong state after reset");
    AST_KBD_OFF: assert property (wr_cmd && dat_i[7:0] == `KBCMD_C_KBD_DIS
        |-> ##[1:4] !kbd_clock_line_oe_n_o)
        else $error("keyboard clock not held after disable");
    AST_KBD_ON: assert property (wr_cmd && dat_i[7:0] == `KBCMD_C_KBD_EN
        |-> ##[1:4] kbd_clock_line_oe_n_o)
        else $error("keyboard clock not released after enable");
    AST_PULSE_LOW: assert property (wr_cmd && dat_i[7:0] == 8'hf3
        && !ext_mode_i |-> ##[1:4] output_port_o[3:2] == 2'b00)
        else $error("pulse did not start");
    AST_PULSE_MAX: assert property (lo_cnt < 9'd170)
        else $error("pulse too long");
    AST_PULSE_MIN: assert property ($rose(output_port_o[2]) && !ext_mode_i
        |-> $past(lo_cnt) >= 9'd140)
        else $error("pulse too short");
    AST_TX_SOLE: assert property (kbd_tx_o |-> !ptr_tx_o ##1 !kbd_tx_o)
        else $error("keyboard send pulse malformed");
endmodule

bind kbcmd_top kbcmd_top_checker i_chk
(
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .ext_mode_i, .kbd_clock_line_oe_n_o, .output_port_o,
    .kbd_irq_o, .pointer_irq_o, .kbd_tx_o, .ptr_tx_o
);
`default_nettype wire

/* File: tb/kbcmd_line_model.sv */
// keyboard and pointer cable model with pull-ups on every line
`timescale 1ns/1ps
`default_nettype none

module kbcmd_line_model
(
    // keyboard clock drive from the decoder
    input  wire logic kbd_clock_line_i,
    input  wire logic kbd_clock_oe_n_i,
    // resolved wire levels
    output wire logic kbd_clock_o,
    output wire logic kbd_data_o,
    output wire logic ptr_clock_o,
    output wire logic ptr_data_o
);
    // released lines float up; devices idle with lines released
    assign kbd_clock_o = kbd_clock_oe_n_i ? 1'b1 : kbd_clock_line_i;
    assign kbd_data_o  = 1'b1;
    assign ptr_clock_o = 1'b1;
    assign ptr_data_o  = 1'b1;
endmodule
`default_nettype wire

/* File: tb/kbcmd_top_bench.sv */
// self-checking bench of the keyboard controller command decoder
`timescale 1ns/1ps
`default_nettype none
`include "kbcmd_regs.vh"

module kbcmd_top_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0;
    logic        ext_mode_i = 1'b0;
    logic [7:0]  input_port_i = 8'ha5;
    logic [7:0]  kb_last = 8'h00;
    logic [7:0]  pt_last = 8'h00;
    logic [7:0]  q;
    wire  [31:0] dat_o;
    wire  [7:0]  output_port_o;
    wire  [7:0]  tx_data_o;
    wire         ack_o, kbd_clock_line_o, kbd_clock_line_oe_n_o, kbd_irq_o;
    wire         pointer_irq_o, kbd_tx_o, ptr_tx_o;
    wire         kck, kdt, pck, pdt;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #20 clk_i = ~clk_i;

    kbcmd_top i_dut
    (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .ext_mode_i, .input_port_i,
        .kbd_clock_line_i(kck), .kbd_data_line_i(kdt),
        .ptr_clock_line_i(pck), .ptr_data_line_i(pdt),
        .kbd_clock_line_o, .kbd_clock_line_oe_n_o, .output_port_o,
        .kbd_irq_o, .pointer_irq_o, .tx_data_o, .kbd_tx_o, .ptr_tx_o
    );

    kbcmd_line_model i_lines
    (
        .kbd_clock_line_i(kbd_clock_line_o),
        .kbd_clock_oe_n_i(kbd_clock_line_oe_n_o),
        .kbd_clock_o(kck), .kbd_data_o(kdt),
        .ptr_clock_o(pck), .ptr_data_o(pdt)
    );

    // send pulses last one cycle, so catch the byte here
    always @(posedge clk_i)
    begin
        if (kbd_tx_o === 1'b1) kb_last <= tx_data_o;
        if (ptr_tx_o === 1'b1) pt_last <= tx_data_o;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic fail(input string nm);
        n_mismatch++;
        $display("ERROR %s expected 1 seen timeout", nm);
        summarize();
    endtask

    // one classic cycle; two idle edges let late side effects land
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        r = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) fail("ack");
        repeat (2) @(posedge clk_i);
    endtask

    task automatic cmd(input logic [7:0] c);
        logic [7:0] r;
        wb(1'b1, `KBCMD_ADDR_CMD, c, r);
    endtask

    task automatic wrd(input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, `KBCMD_ADDR_DATA, d, r);
    endtask

    task automatic sts(output logic [7:0] r);
        wb(1'b0, `KBCMD_ADDR_STATUS, 8'h00, r);
    endtask

    task automatic wfull;
        logic [7:0] s;
        int n;
        s = 8'h00;
        for (n = 0; n < 40 && s[0] !== 1'b1; n++) sts(s);
        if (s[0] !== 1'b1) fail("out_full");
    endtask

    task automatic rdb(output logic [7:0] r);
        wfull();
        wb(1'b0, `KBCMD_ADDR_DATA, 8'h00, r);
    endtask

    task automatic cbuf(input string nm, input logic [7:0] c, e);
        logic [7:0] r;
        cmd(c);
        rdb(r);
        chk(nm, e, r);
    endtask

    task automatic reset_dut(input logic ext);
        rst_i <= 1'b1;
        ext_mode_i <= ext;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    initial
    begin
        reset_dut(1'b0);
        wb(1'b0, `KBCMD_ADDR_MODE, 8'h00, q);
        chk("mode", `KBCMD_MODE_RESET, q);
        chk("port", `KBCMD_OPORT_RESET, output_port_o);
        wb(1'b1, 4'h2, 8'hff, q);
        wb(1'b0, 4'h2, 8'h00, q);
        chk("unmapped", 8'h00, q);
        cmd(`KBCMD_C_WR_MODE);
        wrd(8'h01);
        cmd(`KBCMD_C_SELF_TEST);
        wfull();
        chk("kbd_irq", 8'h01, {7'h0, kbd_irq_o});
        rdb(q);
        chk("self", `KBCMD_SELF_OK, q);
        chk("kbd_irq_clr", 8'h00, {7'h0, kbd_irq_o});
        sts(q);
        chk("full_clr", 8'h00, q & 8'h01);
        cbuf("kbd_test", `KBCMD_C_KBD_TEST, 8'h00);
        cmd(`KBCMD_C_KBD_DIS);
        chk("kbd_clock_line_hold", 8'h00, {7'h0, kbd_clock_line_oe_n_o});
        cbuf("mode_dis", `KBCMD_C_RD_MODE, 8'h11);
        wrd(8'h5a);
        chk("kbd_byte", 8'h5a, kb_last);
        chk("kbd_clock_line_free", 8'h01, {7'h0, kbd_clock_line_oe_n_o});
        cmd(`KBCMD_C_KBD_DIS);
        cmd(`KBCMD_C_KBD_EN);
        chk("kbd_clock_line_on", 8'h01, {7'h0, kbd_clock_line_oe_n_o});
        cbuf("mode_en", `KBCMD_C_RD_MODE, 8'h01);
        $display("test keyboard enable done");
        cmd(`KBCMD_C_SELF_TEST);
        wfull();
        cbuf("in_port", `KBCMD_C_RD_IN, 8'ha5);
        cmd(`KBCMD_C_WR_OUT);
        wrd(8'h0c);
        chk("port_wr", 8'hcc, output_port_o);
        cmd(`KBCMD_C_RD_TEST);
        rdb(q);
        chk("test_in", 8'h03, q & 8'hfb);
        cbuf("out_port", `KBCMD_C_RD_OUT, 8'h0c);
        for (int i = 0; i < 4; i++)
        begin
            cmd(8'hf3 + 8'(i * 4));
            repeat (2) @(posedge clk_i);
            chk("pulse", {6'h0, i[1:0]}, {6'h0, output_port_o[3:2]});
            repeat (170) @(posedge clk_i);
            chk("pulse_end", 8'h03, {6'h0, output_port_o[3:2]});
        end
        cmd(`KBCMD_C_DUMP);
        for (int i = 0; i < 17; i++)
        begin
            rdb(q);
            chk("dump", (i == 16) ? 8'ha5 : 8'h00, q);
        end
        rdb(q);
        chk("dump_port", 8'h0c, q);
        cmd(`KBCMD_C_POLL_LO);
        sts(q);
        chk("reserved", 8'h10, q & 8'hf1);
        $display("test legacy ports done");
        reset_dut(1'b1);
        cmd(`KBCMD_C_WR_MODE);
        wrd(8'h03);
        cmd(`KBCMD_C_WR_KBUF);
        wrd(8'h3c);
        wfull();
        chk("kbd_irq_inj", 8'h01, {7'h0, kbd_irq_o});
        sts(q);
        chk("src_kbd", 8'h00, q & 8'h20);
        rdb(q);
        chk("kbuf", 8'h3c, q);
        cmd(`KBCMD_C_WR_PBUF);
        wrd(8'h7e);
        wfull();
        chk("pirq", 8'h01, {7'h0, pointer_irq_o});
        sts(q);
        chk("src_ptr", 8'h20, q & 8'h20);
        rdb(q);
        chk("pbuf", 8'h7e, q);
        cmd(`KBCMD_C_WR_PTR);
        wrd(8'h91);
        chk("ptr_byte", 8'h91, pt_last);
        cmd(`KBCMD_C_POLL_LO);
        sts(q);
        chk("poll_lo", 8'h50, q & 8'hf0);
        cmd(`KBCMD_C_POLL_HI);
        sts(q);
        chk("poll_hi", 8'ha0, q & 8'hf0);
        cmd(8'hf3);
        repeat (4) @(posedge clk_i);
        chk("no_pulse", 8'h03, {6'h0, output_port_o[3:2]});
        sts(q);
        chk("poll_off", 8'h00, q & 8'hc0);
        cmd(`KBCMD_C_DUMP);
        repeat (4) @(posedge clk_i);
        sts(q);
        chk("dump_ext", 8'h00, q & 8'h01);
        cbuf("out_port_ext", `KBCMD_C_RD_OUT, 8'hcf);
        cbuf("ptr_test", `KBCMD_C_MOUSE_TEST, 8'h00);
        $display("test extended mode done");
        summarize();
    end
endmodule
`default_nettype wire
